// >>> lssl_consts.svh
/*
 * Constants of the LED sink shift and latch controller: widths, status field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and controller files of the block.
 */
`ifndef LSSL_CONSTS_SVH
`define LSSL_CONSTS_SVH

`define LSSL_CHANNELS       16
`define LSSL_SHIFT_RESET    16'h0000
`define LSSL_LATCH_RESET    16'h0000
`define LSSL_STATUS_RESET   16'h0000
`define LSSL_TEMP_BIT       15
`define LSSL_CLK_PERIOD_PS  5000
`define LSSL_SHIFT_HOLD_NS  100
`define LSSL_SHIFT_HOLD_CYC ((`LSSL_SHIFT_HOLD_NS * 1000 + `LSSL_CLK_PERIOD_PS - 1) / `LSSL_CLK_PERIOD_PS)
`define LSSL_STAT_IRQ_OPEN  0
`define LSSL_STAT_IRQ_TEMP  1
`define LSSL_STAT_IRQ_EARLY 2
`define LSSL_IRQ_BITS       3

`endif

// >>> lssl_pkg.sv
/*
 * Types shared by the LED sink shift and latch controller.
 * Assumes the constants header is compiled with it.
 */
`include "lssl_consts.svh"

package lssl_pkg;
	typedef logic [`LSSL_CHANNELS-1:0] lssl_word_t;
	typedef logic [`LSSL_IRQ_BITS-1:0] lssl_irq_t;
endpackage

// >>> lssl_sync.sv
/*
 * Two-flop synchroniser with rising and falling edge detection.
 * Assumes the input is asynchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module lssl_sync (
	// Clock, reset and enable.
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// Raw pin and conditioned outputs.
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// Only sync_r reads meta_r, so no gate ever sees the metastable flop.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (clk_en) begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Edges are one-cycle pulses while enabled.
	assign level = sync_r;
	assign rise  = clk_en & sync_r & ~prev_r;
	assign fall  = clk_en & ~sync_r & prev_r;
endmodule

`default_nettype wire

// >>> lssl_irq.sv
/*
 * Sticky event status with enable and write-one-to-clear, one level output.
 * Assumes event pulses and software strobes on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module lssl_irq (
	// Clock, reset and enable.
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	// Events and software controls.
	input  wire lssl_pkg::lssl_irq_t evt,
	input  wire lssl_pkg::lssl_irq_t clr,
	input  wire lssl_pkg::lssl_irq_t ena,
	// Status and request.
	output lssl_pkg::lssl_irq_t     status,
	output logic                    irq
);
	lssl_pkg::lssl_irq_t stat_r;
	lssl_pkg::lssl_irq_t stat_nxt;

	// A set arriving in the clearing cycle wins, so no event is lost.
	assign stat_nxt = (stat_r & ~clr) | evt;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= '0;
		end else if (clk_en) begin
			stat_r <= stat_nxt;
		end
	end

	assign status = stat_r;
	assign irq    = |(stat_r & ena);
endmodule

`default_nettype wire

// >>> lssl_ctrl.sv
/*
 * Serial on/off control path of a 16-channel LED sink driver: shift register,
 * on/off latch, status capture, blanking, chain output and a small register port.
 * Assumes shift clock, latch strobe, blanking and data arrive as asynchronous pins
 * sampled by mclk, with the shift clock much slower than mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lssl_consts.svh"

module lssl_ctrl (
	// Clock, reset and enable.
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	// Serial link pins.
	input  wire logic                 shift_clk,
	input  wire logic                 serial_data_in,
	input  wire logic                 latch_strobe,
	input  wire logic                 blank,
	output logic                      serial_data_out,
	// Analog-side status inputs.
	input  wire lssl_pkg::lssl_word_t led_open_flag,
	input  wire logic                 thermal_warning_flag,
	// Sink controls, one means the sink is on; then the captured status word.
	output lssl_pkg::lssl_word_t      current_sink_outputs,
	output lssl_pkg::lssl_word_t      status_info_latch,
	// Register port.
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [15:0]               reg_rdata,
	// Interrupt request.
	output logic                      irq
);
	localparam logic [3:0] ADDR_LATCH  = 4'h0;
	localparam logic [3:0] ADDR_SHIFT  = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_IRQ_ST = 4'h3;
	localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
	localparam logic [3:0] ADDR_IRQ_CL = 4'h5;
	localparam int unsigned HOLD_CYC = `LSSL_SHIFT_HOLD_CYC;

	logic                 sclk_rise;
	logic                 sdi_lvl;
	logic                 ltc_rise;
	logic                 blk_lvl;
	logic                 blk_rise;

	lssl_pkg::lssl_word_t shift_r, shift_nxt;
	lssl_pkg::lssl_word_t latch_r;
	lssl_pkg::lssl_word_t stat_hold_r;
	lssl_pkg::lssl_word_t stat_meta_r, stat_sync_r;
	lssl_pkg::lssl_word_t status_now;
	logic                 chain_r;
	logic [7:0]           hold_cnt_r;
	logic                 early_shift;
	lssl_pkg::lssl_irq_t  irq_en_r, irq_clr, irq_evt, irq_status;
	logic [15:0]          rdata_r, rdata_sel;

	// Register address match, shared by the write decodes and the read mux.
	function automatic logic addr_is(input logic [3:0] a, input logic [3:0] b);
		return a == b;
	endfunction

	// Pin conditioning for the four serial-side inputs.
	// Data and shift clock pass equal delays, so data set up before the edge is still valid.
	lssl_sync u_sclk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .pin_in(shift_clk),
		.level(), .rise(sclk_rise), .fall());
	lssl_sync u_sdi (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .pin_in(serial_data_in),
		.level(sdi_lvl), .rise(), .fall());
	lssl_sync u_ltc (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .pin_in(latch_strobe),
		.level(), .rise(ltc_rise), .fall());
	lssl_sync u_blk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .pin_in(blank),
		.level(blk_lvl), .rise(blk_rise), .fall());

	// The status pins are quasi-static analog flags; a plain two-flop bus suffices.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_meta_r <= `LSSL_STATUS_RESET;
			stat_sync_r <= `LSSL_STATUS_RESET;
		end else if (clk_en) begin
			stat_meta_r <= {thermal_warning_flag, led_open_flag[`LSSL_TEMP_BIT-1:0]};
			stat_sync_r <= stat_meta_r;
		end
	end

	// channel-aligned status
	// Open flags keep their channel slot; bit 15 carries the thermal warning instead.
	assign status_now = stat_sync_r;

	// status overwrite on latch
	// A latch strobe takes priority over a coincident shift edge.
	assign shift_nxt = ltc_rise  ? status_now :
	                   sclk_rise ? {shift_r[`LSSL_CHANNELS-2:0], sdi_lvl} : shift_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= `LSSL_SHIFT_RESET;
		end else if (clk_en) begin
			shift_r <= shift_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r <= `LSSL_LATCH_RESET;
		end else if (clk_en && ltc_rise) begin
			latch_r <= shift_r;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_hold_r <= `LSSL_STATUS_RESET;
		end else if (clk_en && blk_rise) begin
			stat_hold_r <= status_now;
		end
	end

	assign status_info_latch = blk_lvl ? `LSSL_STATUS_RESET : stat_hold_r;

	assign current_sink_outputs = blk_lvl ? {`LSSL_CHANNELS{1'b0}} : latch_r;

	// update on shift
	// Status loaded by the latch only shows after the next shift edge.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chain_r <= 1'b0;
		end else if (clk_en && sclk_rise) begin
			chain_r <= shift_nxt[`LSSL_CHANNELS-1];
		end
	end
	assign serial_data_out = chain_r;

	// shift hold monitor
	// A shift edge too soon after a latch is still taken, but flagged as an event.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_r <= 8'h00;
		end else if (clk_en) begin
			if (ltc_rise) begin
				hold_cnt_r <= HOLD_CYC[7:0];
			end else if (hold_cnt_r != 8'h00) begin
				hold_cnt_r <= hold_cnt_r - 8'h01;
			end
		end
	end
	assign early_shift = sclk_rise && (hold_cnt_r != 8'h00) && !ltc_rise;

	// Interrupt events: new open or thermal status captured, or early shift.
	assign irq_evt[`LSSL_STAT_IRQ_OPEN]  = blk_rise && (|status_now[`LSSL_TEMP_BIT-1:0]);
	assign irq_evt[`LSSL_STAT_IRQ_TEMP]  = blk_rise && status_now[`LSSL_TEMP_BIT];
	assign irq_evt[`LSSL_STAT_IRQ_EARLY] = early_shift;

	assign irq_clr = (reg_wr && addr_is(reg_addr, ADDR_IRQ_CL)) ?
	                 reg_wdata[`LSSL_IRQ_BITS-1:0] : '0;

	lssl_irq u_irq (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .evt(irq_evt),
		.clr(irq_clr), .ena(irq_en_r), .status(irq_status), .irq(irq));

	// Interrupt enable register.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_r <= '0;
		end else if (clk_en && reg_wr && addr_is(reg_addr, ADDR_IRQ_EN)) begin
			irq_en_r <= reg_wdata[`LSSL_IRQ_BITS-1:0];
		end
	end

	// Read decode; unmapped and write-only addresses read as zero.
	assign rdata_sel = addr_is(reg_addr, ADDR_LATCH)  ? latch_r :
	                   addr_is(reg_addr, ADDR_SHIFT)  ? shift_r :
	                   addr_is(reg_addr, ADDR_STATUS) ? stat_hold_r :
	                   addr_is(reg_addr, ADDR_IRQ_ST) ? {13'h0000, irq_status} :
	                   addr_is(reg_addr, ADDR_IRQ_EN) ? {13'h0000, irq_en_r} : 16'h0000;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 16'h0000;
		end else if (clk_en) begin
			rdata_r <= reg_rd ? rdata_sel : 16'h0000;
		end
	end
	assign reg_rdata = rdata_r;

	AST_LATCH_COPY: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && ltc_rise) |=> (latch_r == $past(shift_r)))
		else $error("latch did not take shift register");

	AST_LATCH_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
		!(clk_en && ltc_rise) |=> $stable(latch_r))
		else $error("latch changed without a latch edge");

	AST_STATUS_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && ltc_rise) |=> (shift_r == $past(status_now)))
		else $error("shift register did not take status");
	AST_SHIFT_IN: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && sclk_rise && !ltc_rise) |=> (shift_r[0] == $past(sdi_lvl)))
		else $error("serial input not captured into bit 0");
	AST_SHIFT_MOVE: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && sclk_rise && !ltc_rise) |=> (shift_r[15:1] == $past(shift_r[14:0])))
		else $error("shift register did not move toward MSB");

	AST_SHIFT_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
		!(clk_en && (sclk_rise || ltc_rise)) |=> $stable(shift_r))
		else $error("shift register changed without an edge");

	AST_HOLD_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && ltc_rise) |=> (hold_cnt_r == HOLD_CYC[7:0]))
		else $error("shift hold window not started by latch");

	AST_EARLY_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && early_shift) |=> irq_status[`LSSL_STAT_IRQ_EARLY])
		else $error("early shift not flagged");
	AST_BLANK_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
		blk_lvl |-> (current_sink_outputs == 16'h0000))
		else $error("outputs on during blanking");
	AST_OUT_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_n)
		!blk_lvl |-> (current_sink_outputs == latch_r))
		else $error("outputs differ from latch while not blanked");
	AST_SID_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && blk_rise) |=> (stat_hold_r == $past(status_now)))
		else $error("status latch missed blanking edge");

	AST_SID_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
		!(clk_en && blk_rise) |=> $stable(stat_hold_r))
		else $error("status latch changed without blanking edge");

	AST_SID_SHOWN: assert property (@(posedge mclk) disable iff (!rst_n)
		!blk_lvl |-> (status_info_latch == stat_hold_r))
		else $error("status latch not shown while unblanked");

	AST_SID_BLANK: assert property (@(posedge mclk) disable iff (!rst_n)
		blk_lvl |-> (status_info_latch == 16'h0000))
		else $error("status latch shown during blanking");

	AST_SERIAL_DATA_OUT_MSB: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && sclk_rise && !ltc_rise) |=> (serial_data_out == shift_r[15]))
		else $error("serial output not the shift register MSB");
	AST_SERIAL_DATA_OUT_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
		!(clk_en && sclk_rise) |=> $stable(serial_data_out))
		else $error("serial output changed without a shift edge");

	// Read data must be zero outside the cycle after a read strobe.
	AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && !reg_rd) |=> (reg_rdata == 16'h0000))
		else $error("read data not zero without a read");

	// A latch read returns the latch as it stood at the strobe.
	AST_RDATA_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && reg_rd && addr_is(reg_addr, ADDR_LATCH)) |=> (reg_rdata == $past(latch_r)))
		else $error("latch read returned wrong data");

	// An enable write lands in the next cycle.
	AST_EN_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && reg_wr && addr_is(reg_addr, ADDR_IRQ_EN)) |=>
		(irq_en_r == $past(reg_wdata[2:0])))
		else $error("interrupt enable write lost");
endmodule

`default_nettype wire

// >>> lssl_host.sv
/*
 * Behavioural host controller that drives the serial link pins of the driver.
 * Assumes it runs from delays, unrelated in phase to mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module lssl_host (
	// Link pins toward the driver.
	output logic shift_clk,
	output logic serial_data_in,
	output logic latch_strobe,
	output logic blank
);
	// Idle levels; the shift clock rests low outside frames.
	initial begin
		shift_clk      = 1'b0;
		serial_data_in = 1'b0;
		latch_strobe   = 1'b0;
		blank          = 1'b0;
	end

	// One bit on a 48 ns clock; data stands from half a period before the rise until the fall.
	task automatic shift_bit(input logic d);
		serial_data_in = d;
		#24 shift_clk = 1'b1;
		#24 shift_clk = 1'b0;
	endtask

	// A full word, most significant bit first, so it ends in the same position.
	task automatic shift_word(input logic [15:0] d);
		for (int i = 15; i >= 0; i--) begin
			shift_bit(d[i]);
		end
	endtask

	task automatic latch_word;
		#24 latch_strobe = 1'b1;
		#24 latch_strobe = 1'b0;
		#100;
	endtask

	// Blanking is a plain level.
	task automatic set_blank(input logic b);
		blank = b;
	endtask
endmodule

`default_nettype wire

// >>> lssl_ctrl_tb.sv
/*
 * Self-checking bench of the LED sink shift and latch controller.
 * Assumes the host model drives the link pins and the bench the register port.
 */
`timescale 1ns/1ps
`default_nettype none

module lssl_ctrl_tb;
	logic                 mclk, rst_n, clk_en, thermal_warning_flag, irq;
	logic                 shift_clk, serial_data_in, latch_strobe, blank, serial_data_out;
	logic                 reg_wr, reg_rd;
	logic [3:0]           reg_addr;
	logic [15:0]          reg_wdata, reg_rdata, rd;
	lssl_pkg::lssl_word_t led_open_flag, current_sink_outputs, status_info_latch;
	int                   error_cnt, checked;
	localparam logic [15:0] WA = 16'ha5c3;
	localparam logic [15:0] WB = 16'h3c0f;
	localparam logic [15:0] ST = 16'h8421;

	lssl_host host (.shift_clk(shift_clk), .serial_data_in(serial_data_in),
		.latch_strobe(latch_strobe), .blank(blank));

	lssl_ctrl dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .shift_clk(shift_clk),
		.serial_data_in(serial_data_in), .latch_strobe(latch_strobe), .blank(blank),
		.serial_data_out(serial_data_out), .led_open_flag(led_open_flag),
		.thermal_warning_flag(thermal_warning_flag),
		.current_sink_outputs(current_sink_outputs), .status_info_latch(status_info_latch),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));

	// 200 MHz system clock.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Compare and count; an unknown never passes.
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One-cycle write strobe.
	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe.
	task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic results;
		if (error_cnt == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Whole run is a few microseconds; this bound only cuts a hang.
	initial begin
		#60000;
		error_cnt++;
		results();
	end

	initial begin
		rst_n = 1'b0; clk_en = 1'b1; thermal_warning_flag = 1'b0; led_open_flag = 16'h0000;
		reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
		error_cnt = 0; checked = 0;
		wait_cyc(20);
		rst_n <= 1'b1;
		wait_cyc(2);
		chk("sink_reset", 16'h0000, current_sink_outputs);
		host.shift_word(WA);
		wait_cyc(6);
		chk("chain_msb", {15'h0000, WA[15]}, {15'h0000, serial_data_out});
		reg_read(4'h1, rd); chk("shift_reg", WA, rd);
		led_open_flag <= ST;
		thermal_warning_flag <= 1'b1;
		wait_cyc(4);
		host.latch_word();
		wait_cyc(6);
		chk("sink_latched", WA, current_sink_outputs);
		reg_read(4'h0, rd); chk("latch_reg", WA, rd);
		reg_read(4'h1, rd); chk("shift_status", ST, rd);
		chk("chain_hold", {15'h0000, WA[15]}, {15'h0000, serial_data_out});
		host.shift_bit(1'b0);
		wait_cyc(6);
		chk("chain_status", {15'h0000, ST[14]}, {15'h0000, serial_data_out});
		host.set_blank(1'b1);
		wait_cyc(6);
		chk("sink_blank", 16'h0000, current_sink_outputs);
		led_open_flag <= 16'h0000;
		thermal_warning_flag <= 1'b0;
		wait_cyc(4);
		host.set_blank(1'b0);
		wait_cyc(6);
		chk("status_latch", ST, status_info_latch);
		chk("sink_unblank", WA, current_sink_outputs);
		// Interrupt: masked, then enabled, then cleared.
		reg_read(4'h3, rd); chk("irq_status", 16'h0003, rd);
		chk("irq_masked", 16'h0000, {15'h0000, irq});
		reg_write(4'h4, 16'h0003);
		wait_cyc(2);
		chk("irq_on", 16'h0001, {15'h0000, irq});
		reg_write(4'h5, 16'h0003);
		wait_cyc(2);
		chk("irq_off", 16'h0000, {15'h0000, irq});
		reg_read(4'h3, rd); chk("irq_cleared", 16'h0000, rd);
		// Read-only and unmapped places.
		reg_write(4'h0, 16'hffff);
		reg_read(4'h0, rd); chk("latch_ro", WA, rd);
		reg_read(4'hf, rd); chk("unmapped", 16'h0000, rd);
		host.shift_word(WB);
		host.latch_word();
		wait_cyc(6);
		chk("sink_second", WB, current_sink_outputs);
		results();
	end
endmodule

`default_nettype wire
